// ---- design/alu_inverse_pkg.sv ----
/*
 * Constants, operation codes, encodings and types shared by the predicate-push and
 * reciprocal ALU slice and its seed table.
 * Assumes an 11-bit operation code field and 32-bit source and result words.
 */
package alu_inverse_pkg;

    localparam int OPC_W = 11;
    localparam logic [10:0] OPC_FLOAT_NE_INC = 11'h02B;
    localparam logic [10:0] OPC_INT_NE_SET = 11'h045;
    localparam logic [10:0] OPC_INT_NE_INC = 11'h04D;
    localparam logic [10:0] OPC_RCP_CLAMP_MAX = 11'h084;
    localparam logic [10:0] OPC_RCP_CLAMP_ZERO = 11'h085;
    localparam logic [10:0] OPC_RCP_IEEE = 11'h086;
    localparam logic [10:0] OPC_RSQ_CLAMP_MAX = 11'h087;
    localparam logic [10:0] OPC_RSQ_CLAMP_ZERO = 11'h088;
    localparam logic [10:0] OPC_RSQ_IEEE = 11'h089;
    localparam logic [10:0] OPC_RCP_INT = 11'h093;
    localparam logic [10:0] OPC_RCP_UINT = 11'h094;
    localparam logic [10:0] OPC_RCP_DBL = 11'h095;
    localparam logic [10:0] OPC_RCP_DBL_CLAMP = 11'h096;
    localparam logic [10:0] OPC_RSQ_DBL = 11'h097;
    localparam logic [10:0] OPC_RSQ_DBL_CLAMP = 11'h098;

    // Cycles from an accepted operation to its valid result
    localparam int LATENCY_CYCLES = 2;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    localparam logic [31:0] SGL_ZERO = 32'h0000_0000;
    localparam logic [31:0] SGL_ONE = 32'h3F80_0000;
    localparam logic [31:0] SGL_INF = 32'h7F80_0000;
    localparam logic [31:0] SGL_NAN = 32'h7FC0_0000;
    localparam logic [31:0] SGL_MAX = 32'h7F7F_FFFF;
    localparam logic [31:0] DBL_ONE_HI = 32'h3FF0_0000;
    localparam logic [31:0] DBL_INF_HI = 32'h7FF0_0000;
    localparam logic [31:0] DBL_NAN_HI = 32'h7FF8_0000;
    localparam logic [31:0] DBL_MAX_HI = 32'h7FEF_FFFF;
    localparam logic [10:0] SGL_EXP_MAX = 11'h0FF;
    localparam logic [10:0] DBL_EXP_MAX = 11'h7FF;
    localparam logic [7:0] SGL_BIAS = 8'h7F;
    localparam logic [26:0] SGL_ONE_SIG = 27'h400_0000;

    // Biased result exponents for mantissa 1.0 inputs; inexact results take one less
    localparam logic [12:0] SGL_RCP_EXP = 13'h0FE;
    localparam logic [12:0] DBL_RCP_EXP = 13'h7FE;
    localparam logic [12:0] SGL_RSQ_EXP = 13'h0BF;
    localparam logic [12:0] DBL_RSQ_EXP = 13'h5FF;

    // Integer reciprocal: signed yields 2^31/x, unsigned 2^32/x
    localparam logic [5:0] INT_SHIFT_SIGNED = 6'h0A;
    localparam logic [5:0] INT_SHIFT_UNSIGNED = 6'h09;
    localparam logic [31:0] INT_SAT_SIGNED = 32'h7FFF_FFFF;
    localparam logic [31:0] INT_SAT_UNSIGNED = 32'hFFFF_FFFF;
    localparam logic [31:0] INT_ZERO_RESULT = 32'hFFFF_FFFF;
    localparam logic [9:0] SEED_EXACT = 10'h200;

    localparam int SEED_W = 8;
    localparam int SEED_DEPTH = 256;
    localparam int SEED_HALF = 128;
    localparam int SEED_RCP_NUM = 131072;
    localparam int SEED_RSQ_NUM = 33554432;
    localparam int SEED_CAP = 511;

    typedef logic [SEED_W-1:0] seed_table_t [0:SEED_DEPTH-1];
    typedef enum logic [3:0] {
        KIND_NONE, KIND_FPUSH, KIND_IPUSH, KIND_ISET, KIND_RCP32,
        KIND_RSQ32, KIND_RCP64, KIND_RSQ64, KIND_RCPI, KIND_RCPU
    } op_kind_t;
    typedef enum logic [1:0] {CLAMP_NONE, CLAMP_MAX, CLAMP_ZERO} clamp_t;
    typedef enum logic [1:0] {SPC_ZERO, SPC_INF, SPC_NAN, SPC_MAX} special_t;

endpackage : alu_inverse_pkg

// ---- design/inverse_seed_rom.sv ----
/*
 * Seed table for reciprocal and inverse square root mantissas, 256 by 8 bits.
 * Lower half: reciprocal by top 7 mantissa bits. Upper half: inverse root by
 * exponent parity and top 6 mantissa bits. Read data are registered.
 */
`timescale 1ns/1ps
module inverse_seed_rom (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [7:0] seedAddr,
    output logic [7:0] seedData
);
    function automatic int isqrt(input int n);
        int r;
        int t;
        r = 0;
        for (int b = 15; b >= 0; b--) begin
            t = r | (1 << b);
            if (t * t <= n) begin
                r = t;
            end
        end
        return r;
    endfunction : isqrt

    // Entries hold the fraction below the leading one of 2/x or 2/sqrt(x) at bin centre
    function automatic alu_inverse_pkg::seed_table_t buildTable();
        alu_inverse_pkg::seed_table_t t;
        int v;
        int x;
        for (int i = 0; i < alu_inverse_pkg::SEED_DEPTH; i++) begin
            if (i < alu_inverse_pkg::SEED_HALF) begin
                v = alu_inverse_pkg::SEED_RCP_NUM / (257 + 2 * i);
            end else begin
                x = (129 + 2 * (i % 64)) * (((i / 64) % 2 == 1) ? 2 : 1);
                v = isqrt(alu_inverse_pkg::SEED_RSQ_NUM / x);
            end
            if (v > alu_inverse_pkg::SEED_CAP) begin
                v = alu_inverse_pkg::SEED_CAP;
            end
            t[i] = 8'(v);
        end
        return t;
    endfunction : buildTable

    localparam alu_inverse_pkg::seed_table_t SEED_TABLE = buildTable();

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            seedData <= 8'h00;
        end else begin
            seedData <= SEED_TABLE[seedAddr];
        end
    end
endmodule : inverse_seed_rom

// ---- design/predicate_push_and_reciprocal_alu.sv ----
/*
 * Predicate push/set and reciprocal family ALU slice.
 * Stage 0 decodes and handles special operands, stage 1 reads the seed table,
 * stage 2 assembles the result. Assumes operands stable while opValid is high
 * for one cycle; a new operation may be issued every cycle.
 */
`timescale 1ns/1ps
module predicate_push_and_reciprocal_alu (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic opValid,
    input wire logic [10:0] opCode,
    input wire logic [31:0] src0,
    input wire logic [31:0] src1,
    output logic resultValid,
    output logic [31:0] resultData,
    output logic predicateUpdate,
    output logic predicateExecute,
    output logic opUnsupported
);
    function automatic alu_inverse_pkg::op_kind_t decodeOp(input logic [10:0] c);
        unique case (c)
            alu_inverse_pkg::OPC_FLOAT_NE_INC: return alu_inverse_pkg::KIND_FPUSH;
            alu_inverse_pkg::OPC_INT_NE_INC: return alu_inverse_pkg::KIND_IPUSH;
            alu_inverse_pkg::OPC_INT_NE_SET: return alu_inverse_pkg::KIND_ISET;
            alu_inverse_pkg::OPC_RCP_CLAMP_MAX,
            alu_inverse_pkg::OPC_RCP_CLAMP_ZERO,
            alu_inverse_pkg::OPC_RCP_IEEE: return alu_inverse_pkg::KIND_RCP32;
            alu_inverse_pkg::OPC_RSQ_CLAMP_MAX,
            alu_inverse_pkg::OPC_RSQ_CLAMP_ZERO,
            alu_inverse_pkg::OPC_RSQ_IEEE: return alu_inverse_pkg::KIND_RSQ32;
            alu_inverse_pkg::OPC_RCP_DBL,
            alu_inverse_pkg::OPC_RCP_DBL_CLAMP: return alu_inverse_pkg::KIND_RCP64;
            alu_inverse_pkg::OPC_RSQ_DBL,
            alu_inverse_pkg::OPC_RSQ_DBL_CLAMP: return alu_inverse_pkg::KIND_RSQ64;
            alu_inverse_pkg::OPC_RCP_INT: return alu_inverse_pkg::KIND_RCPI;
            alu_inverse_pkg::OPC_RCP_UINT: return alu_inverse_pkg::KIND_RCPU;
            default: return alu_inverse_pkg::KIND_NONE;
        endcase
    endfunction : decodeOp

    function automatic alu_inverse_pkg::clamp_t decodeClamp(input logic [10:0] c);
        unique case (c)
            alu_inverse_pkg::OPC_RCP_CLAMP_MAX,
            alu_inverse_pkg::OPC_RSQ_CLAMP_MAX,
            alu_inverse_pkg::OPC_RCP_DBL_CLAMP,
            alu_inverse_pkg::OPC_RSQ_DBL_CLAMP: return alu_inverse_pkg::CLAMP_MAX;
            alu_inverse_pkg::OPC_RCP_CLAMP_ZERO,
            alu_inverse_pkg::OPC_RSQ_CLAMP_ZERO: return alu_inverse_pkg::CLAMP_ZERO;
            default: return alu_inverse_pkg::CLAMP_NONE;
        endcase
    endfunction : decodeClamp

    function automatic logic [4:0] msbIndex(input logic [31:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 32; i++) begin
            if (v[i]) begin
                r = 5'(i);
            end
        end
        return r;
    endfunction : msbIndex

    // Upper result word for a special outcome, single or double format
    function automatic logic [31:0] specialWord(input logic dbl, input logic sign,
                                                input alu_inverse_pkg::special_t s);
        logic [31:0] w;
        unique case (s)
            alu_inverse_pkg::SPC_ZERO: w = alu_inverse_pkg::SGL_ZERO;
            alu_inverse_pkg::SPC_INF: w = dbl ? alu_inverse_pkg::DBL_INF_HI : alu_inverse_pkg::SGL_INF;
            alu_inverse_pkg::SPC_NAN: w = dbl ? alu_inverse_pkg::DBL_NAN_HI : alu_inverse_pkg::SGL_NAN;
            alu_inverse_pkg::SPC_MAX: w = dbl ? alu_inverse_pkg::DBL_MAX_HI : alu_inverse_pkg::SGL_MAX;
        endcase
        return {sign | w[31], w[30:0]};
    endfunction : specialWord

    // Single-precision a + 1.0, round to nearest even, denormal input taken as zero
    function automatic logic [31:0] addOne(input logic [31:0] a);
        logic [7:0] e;
        logic aBig;
        logic [7:0] d;
        logic [26:0] bigM;
        logic [26:0] smallM;
        logic [26:0] smallS;
        logic [27:0] sum;
        logic [7:0] eBig;
        logic [4:0] k;
        logic [27:0] n;
        logic [9:0] eo;
        logic rnd;
        logic sgn;
        e = a[30:23];
        aBig = e >= alu_inverse_pkg::SGL_BIAS;
        d = aBig ? e - alu_inverse_pkg::SGL_BIAS : alu_inverse_pkg::SGL_BIAS - e;
        bigM = aBig ? {1'b1, a[22:0], 3'h0} : alu_inverse_pkg::SGL_ONE_SIG;
        smallM = aBig ? alu_inverse_pkg::SGL_ONE_SIG : {1'b1, a[22:0], 3'h0};
        if (d > 8'h1A) begin
            smallS = {26'h0, |smallM};
        end else begin
            smallS = (smallM >> d) | {26'h0, |(smallM & ~(27'h7FF_FFFF << d))};
        end
        sum = a[31] ? {1'b0, bigM} - {1'b0, smallS} : {1'b0, bigM} + {1'b0, smallS};
        eBig = aBig ? e : alu_inverse_pkg::SGL_BIAS;
        k = msbIndex({4'h0, sum});
        n = sum << (5'h1B - k);
        eo = {2'b0, eBig} + {5'h00, k} - 10'h01A;
        rnd = n[3] && ((|n[2:0]) || n[4]);
        sgn = aBig & a[31];
        if (e == alu_inverse_pkg::SGL_EXP_MAX[7:0]) begin
            return a;
        end
        if (e == 8'h00) begin
            return alu_inverse_pkg::SGL_ONE;
        end
        if (sum == 28'h0) begin
            return alu_inverse_pkg::SGL_ZERO;
        end
        if (eo >= {2'b0, alu_inverse_pkg::SGL_EXP_MAX[7:0]}) begin
            return {sgn, alu_inverse_pkg::SGL_INF[30:0]};
        end
        return {sgn, 31'({eo[7:0], n[26:4]}) + 31'(rnd)};
    endfunction : addOne

    // Stage 0: decode
    alu_inverse_pkg::op_kind_t kind;
    alu_inverse_pkg::clamp_t clampMode;
    logic isDbl;
    logic isRsq;
    logic isFloatInv;
    logic isInt;
    logic isPred;
    assign kind = decodeOp(opCode);
    assign clampMode = decodeClamp(opCode);
    assign isDbl = kind == alu_inverse_pkg::KIND_RCP64 || kind == alu_inverse_pkg::KIND_RSQ64;
    assign isRsq = kind == alu_inverse_pkg::KIND_RSQ32 || kind == alu_inverse_pkg::KIND_RSQ64;
    assign isFloatInv = isDbl || isRsq || kind == alu_inverse_pkg::KIND_RCP32;
    assign isInt = kind == alu_inverse_pkg::KIND_RCPI || kind == alu_inverse_pkg::KIND_RCPU;
    assign isPred = kind == alu_inverse_pkg::KIND_FPUSH || kind == alu_inverse_pkg::KIND_IPUSH
                    || kind == alu_inverse_pkg::KIND_ISET;

    // Stage 0: floating operand fields; double takes high half from src0, low from src1
    logic fSign;
    logic [10:0] fExp;
    logic [6:0] fMant7;
    logic fRestZero;
    logic isOne;
    assign fSign = src0[31];
    assign fExp = isDbl ? src0[30:20] : {3'h0, src0[30:23]};
    assign fMant7 = isDbl ? src0[19:13] : src0[22:16];
    assign fRestZero = isDbl ? (src0[12:0] == 13'h0 && src1 == 32'h0) : src0[15:0] == 16'h0;
    assign isOne = isDbl ? (src0 == alu_inverse_pkg::DBL_ONE_HI && src1 == 32'h0)
                         : src0 == alu_inverse_pkg::SGL_ONE;

    logic mantZero;
    logic fZero;
    logic fExpMax;
    logic fNan;
    logic fInf;
    logic exact;
    logic [11:0] halfExp;
    logic [12:0] rcpExp;
    logic [12:0] rsqExp;
    logic [12:0] expOut;
    logic flush;
    assign mantZero = fMant7 == 7'h00 && fRestZero;
    assign fZero = fExp == 11'h000;
    assign fExpMax = fExp == (isDbl ? alu_inverse_pkg::DBL_EXP_MAX : alu_inverse_pkg::SGL_EXP_MAX);
    assign fNan = fExpMax && !mantZero;
    assign fInf = fExpMax && mantZero;
    // A root of a power of two is exact only for an even unbiased exponent
    assign exact = mantZero && (!isRsq || fExp[0]);
    assign halfExp = 12'({1'b0, fExp} + 12'h001) >> 1;
    assign rcpExp = (isDbl ? alu_inverse_pkg::DBL_RCP_EXP : alu_inverse_pkg::SGL_RCP_EXP)
                    - {2'b0, fExp} - {12'h000, !exact};
    assign rsqExp = (isDbl ? alu_inverse_pkg::DBL_RSQ_EXP : alu_inverse_pkg::SGL_RSQ_EXP)
                    - {1'b0, halfExp} - {12'h000, !exact};
    assign expOut = isRsq ? rsqExp : rcpExp;
    // Results below the normal range are flushed to zero
    assign flush = !isRsq && (expOut == 13'h0000 || expOut[12]);

    alu_inverse_pkg::special_t specRaw;
    alu_inverse_pkg::special_t specFinal;
    logic fSpecial;
    logic specSign;
    logic [31:0] floatDirect;
    assign fSpecial = fNan || fZero || fInf || flush || (isRsq && fSign);
    assign specRaw = (fNan || (isRsq && fSign && !fZero)) ? alu_inverse_pkg::SPC_NAN
                   : fZero ? alu_inverse_pkg::SPC_INF : alu_inverse_pkg::SPC_ZERO;
    assign specFinal = (specRaw != alu_inverse_pkg::SPC_INF) ? specRaw
                     : (clampMode == alu_inverse_pkg::CLAMP_MAX) ? alu_inverse_pkg::SPC_MAX
                     : (clampMode == alu_inverse_pkg::CLAMP_ZERO) ? alu_inverse_pkg::SPC_ZERO
                     : alu_inverse_pkg::SPC_INF;
    assign specSign = fSign && specRaw != alu_inverse_pkg::SPC_NAN;
    assign floatDirect = isOne ? (isDbl ? alu_inverse_pkg::DBL_ONE_HI : alu_inverse_pkg::SGL_ONE)
                       : specialWord(isDbl, specSign, specFinal);

    // Stage 0: integer reciprocal normalisation
    logic intNeg;
    logic [31:0] intMag;
    logic [4:0] intK;
    logic [31:0] intNorm;
    logic intExact;
    logic [5:0] intShift;
    assign intNeg = kind == alu_inverse_pkg::KIND_RCPI && src0[31];
    assign intMag = intNeg ? -src0 : src0;
    assign intK = msbIndex(intMag);
    assign intNorm = intMag << (5'h1F - intK);
    assign intExact = intNorm[30:0] == 31'h0;
    assign intShift = (kind == alu_inverse_pkg::KIND_RCPI ? alu_inverse_pkg::INT_SHIFT_SIGNED
                       : alu_inverse_pkg::INT_SHIFT_UNSIGNED) + {1'b0, intK};

    // Stage 0: predicate operations, zero tests treat denormals as zero
    logic src0FZero;
    logic src1FNonZero;
    logic predExec;
    logic [31:0] incResult;
    logic [31:0] predDirect;
    assign src0FZero = src0[30:23] == 8'h00;
    assign src1FNonZero = src1[30:23] != 8'h00;
    assign incResult = addOne(src0);
    assign predExec = (kind == alu_inverse_pkg::KIND_FPUSH) ? src1FNonZero && src0FZero
                    : (kind == alu_inverse_pkg::KIND_IPUSH) ? src1 != 32'h0 && src0FZero
                    : src0 != src1;
    assign predDirect = predExec ? alu_inverse_pkg::SGL_ZERO
                      : (kind == alu_inverse_pkg::KIND_ISET) ? alu_inverse_pkg::SGL_ONE
                      : incResult;

    logic useDirect;
    logic [31:0] directWord;
    logic [7:0] seedAddr;
    assign useDirect = !isFloatInv && !isInt || isFloatInv && (isOne || fSpecial) || isInt && intMag == 32'h0;
    assign directWord = isPred ? predDirect
                      : isFloatInv ? floatDirect
                      : isInt ? alu_inverse_pkg::INT_ZERO_RESULT
                      : alu_inverse_pkg::RESET_WORD;
    assign seedAddr = isInt ? {1'b0, intNorm[30:24]}
                    : isRsq ? {1'b1, ~fExp[0], fMant7[6:1]} : {1'b0, fMant7};

    logic [7:0] seedData;
    inverse_seed_rom seedRom (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .seedAddr(seedAddr),
        .seedData(seedData)
    );

    // Stage 1 registers, aligned with the seed table read
    logic s1Valid_reg;
    logic s1Bad_reg;
    logic s1Pred_reg;
    logic s1Exec_reg;
    logic s1Direct_reg;
    logic [31:0] s1Word_reg;
    logic s1Int_reg;
    logic s1Dbl_reg;
    logic s1Sign_reg;
    logic s1Exact_reg;
    logic [10:0] s1Exp_reg;
    logic s1IntSigned_reg;
    logic s1IntNeg_reg;
    logic [5:0] s1Shift_reg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s1Valid_reg <= 1'b0;
            s1Bad_reg <= 1'b0;
            s1Pred_reg <= 1'b0;
            s1Exec_reg <= 1'b0;
            s1Direct_reg <= 1'b0;
            s1Word_reg <= alu_inverse_pkg::RESET_WORD;
            s1Int_reg <= 1'b0;
            s1Dbl_reg <= 1'b0;
            s1Sign_reg <= 1'b0;
            s1Exact_reg <= 1'b0;
            s1Exp_reg <= 11'h000;
            s1IntSigned_reg <= 1'b0;
            s1IntNeg_reg <= 1'b0;
            s1Shift_reg <= 6'h00;
        end else begin
            s1Valid_reg <= opValid;
            s1Bad_reg <= kind == alu_inverse_pkg::KIND_NONE;
            s1Pred_reg <= isPred;
            s1Exec_reg <= isPred && predExec;
            s1Direct_reg <= useDirect;
            s1Word_reg <= directWord;
            s1Int_reg <= isInt;
            s1Dbl_reg <= isDbl;
            s1Sign_reg <= fSign;
            s1Exact_reg <= isInt ? intExact : exact;
            s1Exp_reg <= expOut[10:0];
            s1IntSigned_reg <= kind == alu_inverse_pkg::KIND_RCPI;
            s1IntNeg_reg <= intNeg;
            s1Shift_reg <= intShift;
        end
    end

    // Stage 2: assemble from the seed; double results keep the upper word only
    logic [22:0] sglFrac;
    logic [19:0] dblFrac;
    logic [31:0] floatWord;
    logic [9:0] seed10;
    logic [63:0] intWide;
    logic [31:0] intLimit;
    logic [31:0] intMagRes;
    logic [31:0] intWord;
    logic [31:0] resultData_next;
    assign sglFrac = s1Exact_reg ? 23'h0 : {seedData, 15'h0000};
    assign dblFrac = s1Exact_reg ? 20'h0 : {seedData, 12'h000};
    assign floatWord = s1Dbl_reg ? {s1Sign_reg, s1Exp_reg, dblFrac}
                                 : {s1Sign_reg, s1Exp_reg[7:0], sglFrac};
    assign seed10 = s1Exact_reg ? alu_inverse_pkg::SEED_EXACT : {2'b01, seedData};
    assign intWide = {22'h0, seed10, 32'h0} >> s1Shift_reg;
    assign intLimit = s1IntSigned_reg ? alu_inverse_pkg::INT_SAT_SIGNED : alu_inverse_pkg::INT_SAT_UNSIGNED;
    assign intMagRes = (intWide[63:32] != 32'h0 || intWide[31:0] > intLimit) ? intLimit : intWide[31:0];
    assign intWord = s1IntNeg_reg ? -intMagRes : intMagRes;
    assign resultData_next = s1Bad_reg ? alu_inverse_pkg::RESET_WORD
                           : s1Direct_reg ? s1Word_reg
                           : s1Int_reg ? intWord : floatWord;

    logic resultValid_reg;
    logic [31:0] resultData_reg;
    logic predicateUpdate_reg;
    logic predicateExecute_reg;
    logic opUnsupported_reg;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            resultValid_reg <= 1'b0;
            resultData_reg <= alu_inverse_pkg::RESET_WORD;
            predicateUpdate_reg <= 1'b0;
            predicateExecute_reg <= 1'b0;
            opUnsupported_reg <= 1'b0;
        end else begin
            resultValid_reg <= s1Valid_reg;
            resultData_reg <= s1Valid_reg ? resultData_next : alu_inverse_pkg::RESET_WORD;
            predicateUpdate_reg <= s1Valid_reg && s1Pred_reg;
            predicateExecute_reg <= s1Valid_reg && s1Exec_reg;
            opUnsupported_reg <= s1Valid_reg && s1Bad_reg;
        end
    end

    assign resultValid = resultValid_reg;
    assign resultData = resultData_reg;
    assign predicateUpdate = predicateUpdate_reg;
    assign predicateExecute = predicateExecute_reg;
    assign opUnsupported = opUnsupported_reg;
endmodule : predicate_push_and_reciprocal_alu

// ---- dv/alu_slice_chk.sv ----
/* Port checker of the ALU slice; bound to its top module at the foot of this file. */
`timescale 1ns/1ps
module alu_slice_chk (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic opValid,
    input wire logic [10:0] opCode,
    input wire logic [31:0] src0,
    input wire logic [31:0] src1,
    input wire logic resultValid,
    input wire logic [31:0] resultData,
    input wire logic predicateUpdate,
    input wire logic predicateExecute,
    input wire logic opUnsupported
);
    // Idle cycles decode to a code that no operation uses
    wire [10:0] c = opValid ? opCode : 11'h7FF;
    wire z0 = src0 == 32'h0;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    lat_fixed_a: assert property (opValid |-> ##2 resultValid) else $error("result late");
    no_extra_a: assert property (resultValid |-> $past(opValid, 2)) else $error("result unasked");
    unsup_flag_a: assert property (opValid |-> ##2 opUnsupported == !($past(opCode, 2) inside {11'h02B,
        11'h045, 11'h04D, [11'h084:11'h089], [11'h093:11'h098]})) else $error("unsupported flag");
    float_push_a: assert property (c == 11'h02B && z0 && src1[30:23] != 8'h0 |->
        ##2 predicateExecute && resultData == 32'h0) else $error("float push");
    int_push_a: assert property (c == 11'h04D && z0 && src1 != 32'h0 |->
        ##2 predicateUpdate && predicateExecute) else $error("int push");
    int_set_a: assert property (c == 11'h045 && src0 == src1 |->
        ##2 resultData == 32'h3F80_0000 && !predicateExecute) else $error("int set");
    clamp_max_a: assert property (c == 11'h084 && src0 == 32'h8000_0000 |->
        ##2 resultData == 32'hFF7F_FFFF) else $error("clamp max");
    clamp_zero_a: assert property (c == 11'h085 && z0 |-> ##2 resultData == 32'h0) else $error("clamp zero");
    dbl_one_a: assert property (c == 11'h095 && src0 == 32'h3FF0_0000 && src1 == 32'h0 |->
        ##2 resultData == 32'h3FF0_0000) else $error("double one");
    root_one_a: assert property (c == 11'h089 && src0 == 32'h3F80_0000 |->
        ##2 resultData == 32'h3F80_0000) else $error("root one");
endmodule : alu_slice_chk
bind predicate_push_and_reciprocal_alu alu_slice_chk alu_slice_chk_inst (.clk_sys(clk_sys), .rstn(rstn),
    .opValid(opValid), .opCode(opCode), .src0(src0), .src1(src1), .resultValid(resultValid),
    .resultData(resultData), .predicateUpdate(predicateUpdate), .predicateExecute(predicateExecute),
    .opUnsupported(opUnsupported));

// ---- dv/op_source.sv ----
/* Sequencer and register file stand-in; the bench calls issue once per cycle. */
`timescale 1ns/1ps
module op_source (
    input wire logic clk_sys,
    output logic opValid,
    output logic [10:0] opCode,
    output logic [31:0] src0,
    output logic [31:0] src1
);
    initial {opValid, opCode, src0, src1} = '0;
    // An all-zero request releases the operands, which then toggle
    task issue(input logic [74:0] op);
        @(posedge clk_sys);
        {opValid, opCode, src0, src1} <= op == '0 ? {1'b0, opCode, ~src0, ~src1} : {1'b1, op};
    endtask : issue
endmodule : op_source

// ---- dv/tb_top.sv ----
/* Self-checking bench of the ALU slice; expects the checker bound to the design. */
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic opValid, resultValid, predicateUpdate, predicateExecute, opUnsupported;
    logic [10:0] opCode;
    logic [31:0] src0, src1, resultData;
    logic [43:0] q[$];
    logic [43:0] qe;
    logic [7:0] r = 8'h5C;
    int failures = 0;
    int checkCount = 0;
    initial forever #25 clk_sys = ~clk_sys;
    predicate_push_and_reciprocal_alu predicate_push_and_reciprocal_operation_code_field (.clk_sys(clk_sys), .rstn(rstn),
        .opValid(opValid), .opCode(opCode), .src0(src0), .src1(src1), .resultValid(resultValid),
        .resultData(resultData), .predicateUpdate(predicateUpdate), .predicateExecute(predicateExecute),
        .opUnsupported(opUnsupported));
    op_source op_source_inst (.clk_sys(clk_sys), .opValid(opValid), .opCode(opCode), .src0(src0), .src1(src1));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    // Codes that name an operation; any other one must raise opUnsupported
    function automatic logic isKnownCode(input logic [10:0] c);
        return c inside {11'h02B, 11'h045, 11'h04D, [11'h084:11'h089], [11'h093:11'h098]};
    endfunction : isKnownCode
    task check(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task final_report;
        $display("checks=%0d failures=%0d", checkCount, failures);
        if (failures == 0 && checkCount > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : final_report
    task run(input logic [10:0] c, input logic [31:0] a, b, d, input logic x);
        op_source_inst.issue({c, a, b});
        q.push_back({c, x, d});
    endtask : run
    always @(negedge clk_sys) if (resultValid === 1'b1) begin
        qe = q.pop_front();
        check(resultData, qe[31:0]);
        check({predicateUpdate, predicateExecute, opUnsupported},
            {qe[43:33] inside {11'h02B, 11'h04D, 11'h045}, qe[32], !isKnownCode(qe[43:33])});
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b1;
        run(11'h02B, 32'h0, 32'h3F80_0000, 32'h0, 1'b1);
        run(11'h02B, 32'h3F80_0000, 32'h0, 32'h4000_0000, 1'b0);
        run(11'h04D, 32'h0, 32'h5, 32'h0, 1'b1);
        run(11'h04D, 32'h0, 32'h0, 32'h3F80_0000, 1'b0);
        run(11'h045, 32'h7, 32'h7, 32'h3F80_0000, 1'b0);
        run(11'h095, 32'h4000_0000, 32'h0, 32'h3FE0_0000, 1'b0);
        run(11'h095, 32'h3FF0_0000, 32'h0, 32'h3FF0_0000, 1'b0);
        run(11'h096, 32'h0, 32'h0, 32'h7FEF_FFFF, 1'b0);
        run(11'h084, 32'h8000_0000, 32'h0, 32'hFF7F_FFFF, 1'b0);
        run(11'h085, 32'h0, 32'h0, 32'h0, 1'b0);
        run(11'h093, 32'hFFFF_FFFE, 32'h0, 32'hC000_0000, 1'b0);
        run(11'h094, 32'h2, 32'h0, 32'h8000_0000, 1'b0);
        run(11'h097, 32'h4010_0000, 32'h0, 32'h3FE0_0000, 1'b0);
        run(11'h087, 32'h0, 32'h0, 32'h7F7F_FFFF, 1'b0);
        run(11'h098, 32'h8000_0000, 32'h0, 32'hFFEF_FFFF, 1'b0);
        run(11'h088, 32'h0, 32'h0, 32'h0, 1'b0);
        run(11'h089, 32'h3F80_0000, 32'h0, 32'h3F80_0000, 1'b0);
        run(11'h086, 32'h0, 32'h0, 32'h7F80_0000, 1'b0);
        run(11'h089, 32'h7F80_0000, 32'h0, 32'h0, 1'b0);
        run(11'h087, 32'hBF80_0000, 32'h0, 32'h7FC0_0000, 1'b0);
        run(11'h123, 32'h3F80_0000, 32'h3F80_0000, 32'h0, 1'b0);
        for (int i = 0; i < 24; i++) begin
            r = lfsr(r);
            run(11'h045, {24'h0, r}, {24'h0, r & 8'h3}, r > 8'h3 ? 32'h0 : 32'h3F80_0000, r > 8'h3);
            run(11'h086, {1'b0, r[6:0] + 8'h40, 23'h0}, 32'h0, {1'b0, 8'hBE - r[6:0], 23'h0}, 1'b0);
        end
        op_source_inst.issue('0);
        for (int k = 0; k < 8 && q.size() > 0; k++) @(posedge clk_sys);
        if (q.size() != 0) failures++;
        final_report();
    end
endmodule : tb_top
